// file: pkg/boot_select_defs.vh
// constants for the reset-time boot mode selection block
`ifndef BOOT_SELECT_DEFS_VH
`define BOOT_SELECT_DEFS_VH

// boot selection codes {upper, lower}
`define SEL_USER        2'b11
`define SEL_STANDARD    2'b10
`define SEL_SELECTIVE   2'b01
`define SEL_RESERVED    2'b00

// mode outputs
`define MODE_W          2
`define MODE_USER       2'h0
`define MODE_STANDARD   2'h1
`define MODE_SELECTIVE  2'h2
`define MODE_RESERVED   2'h3

// key outcomes
`define KEY_W           2
`define KEY_TO_STANDARD 2'h0
`define KEY_SERIAL_ONLY 2'h1
`define KEY_CAN_ONLY    2'h2
`define KEY_HALT        2'h3

// flash word widths and signature
`define WORD_W          16
`define ADDR_W          24
`define SIG_LOC_A       24'h00_0000
`define SIG_LOC_B       24'h00_0002
`define KEY_LOC         24'h00_0004
`define SIG_ZERO        16'h0000

// dominant-bit validation: consecutive low samples
`define DOM_CNT_W       4
`define DOM_SAMPLES     4'h8
`define SYNC_ZERO       2'b00
`define SYNC_ONES       2'b11
`define SYNC_IDLE4      4'hf

`endif

// file: rtl/line_sync.v
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module line_sync #(
    parameter W = 4                  // number of lines
) (
    input  wire         clk,         // system clock
    input  wire         srst,        // synchronous reset, active high
    input  wire [W-1:0] rst_val,     // value held during reset
    input  wire [W-1:0] pin_in,      // asynchronous pin levels
    output reg  [W-1:0] sync_out     // synchronised levels
);
    reg [W-1:0] meta_reg;            // first stage, read only by stage two

    // ------------------------------------------------------------
    // two flip-flop chain
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            meta_reg <= rst_val;
            sync_out <= rst_val;
        end else begin
            meta_reg <= pin_in;
            sync_out <= meta_reg;
        end
    end
endmodule // line_sync

// file: rtl/boot_select.v
// reset-time boot mode selection and bootstrap channel detection
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/10ps
`include "boot_select_defs.vh"
module boot_select (
    input  wire                 clk,                      // 125 MHz clock
    input  wire                 srst,                     // sync reset, high
    input  wire                 external_reset_input,     // reset pin, low=rst
    input  wire                 boot_select_upper,        // strap pin
    input  wire                 boot_select_lower,        // strap pin
    input  wire                 serial0_receive_line,     // uart rx pin
    input  wire                 can_channel1_receive_line,// can rx pin
    input  wire [`WORD_W-1:0]   ref_signature,            // reference value
    output reg  [`ADDR_W-1:0]   flash_addr,               // flash read address
    output reg                  flash_rd,                 // flash read strobe
    input  wire [`WORD_W-1:0]   flash_rdata,              // data, next cycle
    output reg  [`MODE_W-1:0]   boot_mode,                // latched mode
    output reg                  fetch_from_test_flash,    // fetch redirect
    output reg                  user_flash_enable,        // user flash on
    output reg                  soft_reset_req,           // one-cycle pulse
    output reg                  run_user_code,            // user code level
    output reg                  standard_boot_loader,     // loader active
    output reg                  serial_boot_start,        // serial chosen
    output reg                  can_boot_start,           // can chosen
    output reg                  halt_loop,                // endless loop
    output reg                  boot_done                 // decision made
);
    // state codes, one-hot
    localparam [7:0] S_IDLE = 8'h01;  // waiting for reset release
    localparam [7:0] S_SIGA = 8'h02;  // reading signature location a
    localparam [7:0] S_SIGB = 8'h04;  // reading signature location b
    localparam [7:0] S_CHK  = 8'h08;  // comparing signature
    localparam [7:0] S_KEY  = 8'h10;  // reading key location
    localparam [7:0] S_KEYD = 8'h20;  // decoding key
    localparam [7:0] S_POLL = 8'h40;  // polling receive lines
    localparam [7:0] S_DONE = 8'h80;  // final outcome holds

    wire [3:0]          sync_w;       // synchronised pins
    reg  [7:0]          state_reg;    // current state
    reg  [7:0]          state_next;   // next state
    reg                 rst_prev_reg; // reset pin last cycle
    reg  [`WORD_W-1:0]  sig_a_reg;    // first signature word
    reg  [`DOM_CNT_W-1:0] dom_cnt_reg;// consecutive dominant samples
    reg                 ser_prev_reg; // serial line last cycle
    reg                 can_only_reg; // only can is listened to
    reg                 ser_only_reg; // only serial is listened to

    wire rst_pin   = sync_w[0];
    wire sel_upper = sync_w[1];
    wire sel_lower = sync_w[2];
    wire ser_line  = sync_w[3];
    wire rst_rise  = rst_pin & ~rst_prev_reg;

    // all pins settle before use; idle levels are high
    line_sync #(.W(4)) u_sync (
        .clk      (clk),
        .srst     (srst),
        .rst_val  (`SYNC_IDLE4),
        .pin_in   ({serial0_receive_line, boot_select_lower,
                    boot_select_upper, external_reset_input}),
        .sync_out (sync_w)
    );

    reg [1:0] can_sync_reg;           // can rx synchroniser

    // ------------------------------------------------------------
    // can line synchroniser, stage 0 read only by stage 1
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst)
            can_sync_reg <= `SYNC_ONES;
        else
            can_sync_reg <= {can_sync_reg[0], can_channel1_receive_line};
    end
    wire can_line = can_sync_reg[1];

    // decode strap pair into a mode code
    function [`MODE_W-1:0] decode_mode;
        input [1:0] sel;
        begin
            case (sel)
                `SEL_USER:      decode_mode = `MODE_USER;
                `SEL_STANDARD:  decode_mode = `MODE_STANDARD;
                `SEL_SELECTIVE: decode_mode = `MODE_SELECTIVE;
                default:        decode_mode = `MODE_RESERVED;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (rst_rise) begin
                    case (decode_mode({sel_upper, sel_lower}))
                        `MODE_STANDARD:  state_next = S_POLL;
                        `MODE_SELECTIVE: state_next = S_SIGA;
                        default:         state_next = S_DONE;
                    endcase
                end
            end
            S_SIGA: state_next = S_SIGB;
            S_SIGB: state_next = S_CHK;
            S_CHK: begin
                if ((sig_a_reg ^ flash_rdata) == ref_signature)
                    state_next = S_DONE;
                else
                    state_next = S_KEY;
            end
            S_KEY:  state_next = S_KEYD;
            S_KEYD: begin
                if (flash_rdata[`KEY_W-1:0] == `KEY_HALT)
                    state_next = S_DONE;
                else
                    state_next = S_POLL;
            end
            S_POLL: begin
                if ((ser_prev_reg & ~ser_line & ~can_only_reg) ||
                    (dom_cnt_reg == `DOM_SAMPLES && !ser_only_reg))
                    state_next = S_DONE;
            end
            S_DONE:  state_next = S_DONE;
            default: state_next = S_IDLE;
        endcase
        if (!rst_pin)
            state_next = S_IDLE;   // pin reset restarts the decision
    end

    // ------------------------------------------------------------
    // state, strap latch and outcome registers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state_reg             <= S_IDLE;
            rst_prev_reg          <= 1'b1;
            sig_a_reg             <= `SIG_ZERO;
            dom_cnt_reg           <= {`DOM_CNT_W{1'b0}};
            ser_prev_reg          <= 1'b1;
            can_only_reg          <= 1'b0;
            ser_only_reg          <= 1'b0;
            flash_addr            <= `SIG_LOC_A;
            flash_rd              <= 1'b0;
            boot_mode             <= `MODE_USER;
            fetch_from_test_flash <= 1'b0;
            user_flash_enable     <= 1'b0;
            soft_reset_req        <= 1'b0;
            run_user_code         <= 1'b0;
            standard_boot_loader  <= 1'b0;
            serial_boot_start     <= 1'b0;
            can_boot_start        <= 1'b0;
            halt_loop             <= 1'b0;
            boot_done             <= 1'b0;
        end else begin
            state_reg      <= state_next;
            rst_prev_reg   <= rst_pin;
            ser_prev_reg   <= ser_line;
            flash_rd       <= 1'b0;
            soft_reset_req <= 1'b0;
            // dominant bit must hold several samples to count as valid
            if (state_reg == S_POLL && !can_line) begin
                if (dom_cnt_reg != `DOM_SAMPLES)
                    dom_cnt_reg <= dom_cnt_reg + 1'b1;
            end else begin
                dom_cnt_reg <= {`DOM_CNT_W{1'b0}};
            end
            case (state_reg)
                S_IDLE: begin
                    if (rst_rise) begin
                        boot_mode <= decode_mode({sel_upper, sel_lower});
                        user_flash_enable <= 1'b1;
                        fetch_from_test_flash <=
                            (decode_mode({sel_upper, sel_lower})
                             == `MODE_STANDARD) ||
                            (decode_mode({sel_upper, sel_lower})
                             == `MODE_SELECTIVE);
                        standard_boot_loader <=
                            (decode_mode({sel_upper, sel_lower})
                             == `MODE_STANDARD);
                        run_user_code <=
                            (decode_mode({sel_upper, sel_lower})
                             == `MODE_USER);
                        boot_done <=
                            (decode_mode({sel_upper, sel_lower})
                             == `MODE_USER);
                        flash_addr <= `SIG_LOC_A;
                        flash_rd   <= (decode_mode({sel_upper, sel_lower})
                                       == `MODE_SELECTIVE);
                    end
                end
                S_SIGA: begin
                    // first word is still on its way; ask for the second
                    flash_addr <= `SIG_LOC_B;
                    flash_rd   <= 1'b1;
                end
                S_SIGB: begin
                    // flash answers one cycle after the strobe, so the
                    // first word is only on the bus now
                    sig_a_reg  <= flash_rdata;
                end
                S_CHK: begin
                    if ((sig_a_reg ^ flash_rdata) == ref_signature) begin
                        soft_reset_req        <= 1'b1;
                        run_user_code         <= 1'b1;
                        fetch_from_test_flash <= 1'b0;
                        boot_done             <= 1'b1;
                    end else begin
                        flash_addr <= `KEY_LOC;
                        flash_rd   <= 1'b1;
                    end
                end
                S_KEY: ;   // key word arrives next cycle
                S_KEYD: begin
                    case (flash_rdata[`KEY_W-1:0])
                        `KEY_TO_STANDARD: standard_boot_loader <= 1'b1;
                        `KEY_SERIAL_ONLY: ser_only_reg <= 1'b1;
                        `KEY_CAN_ONLY:    can_only_reg <= 1'b1;
                        default: begin
                            halt_loop <= 1'b1;
                            boot_done <= 1'b1;
                        end
                    endcase
                end
                S_POLL: begin
                    // serial start edge checked first, then can
                    if (ser_prev_reg & ~ser_line & ~can_only_reg) begin
                        serial_boot_start <= 1'b1;
                        boot_done         <= 1'b1;
                    end else if (dom_cnt_reg == `DOM_SAMPLES &&
                                 !ser_only_reg) begin
                        can_boot_start    <= 1'b1;
                        boot_done         <= 1'b1;
                    end
                end
                S_DONE: ;  // outcome holds until next pin reset
                default: ;
            endcase
            if (!rst_pin) begin
                // pin reset clears the outcome, strap kept until edge
                user_flash_enable    <= 1'b0;
                run_user_code        <= 1'b0;
                standard_boot_loader <= 1'b0;
                serial_boot_start    <= 1'b0;
                can_boot_start       <= 1'b0;
                halt_loop            <= 1'b0;
                boot_done            <= 1'b0;
                can_only_reg         <= 1'b0;
                ser_only_reg         <= 1'b0;
            end
        end
    end
endmodule // boot_select

// file: bench/boot_select_asserts.sv
// port-level checks for the boot selection block
`timescale 1ns/10ps
`include "boot_select_defs.vh"
module boot_select_asserts (
    input wire                clk, srst, external_reset_input,
    input wire                boot_select_upper, boot_select_lower,
    input wire                serial0_receive_line,
    input wire                can_channel1_receive_line,
    input wire [`WORD_W-1:0]  ref_signature, flash_rdata,
    input wire [`ADDR_W-1:0]  flash_addr,
    input wire [`MODE_W-1:0]  boot_mode,
    input wire                flash_rd, fetch_from_test_flash,
    input wire                user_flash_enable, soft_reset_req,
    input wire                run_user_code, standard_boot_loader,
    input wire                serial_boot_start, can_boot_start,
    input wire                halt_loop, boot_done
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    // raw low run on the can pin; the pin is seen two stages early, so a
    // real start always follows at least eight raw low samples
    reg [3:0] can_low_reg;
    always @(posedge clk) begin
        if (srst || can_channel1_receive_line) begin
            can_low_reg <= 4'h0;
        end else if (can_low_reg != 4'hf) begin
            can_low_reg <= can_low_reg + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_read_a; flash_rd && flash_addr == `SIG_LOC_A; endsequence
    sequence s_read_b; flash_rd && flash_addr == `SIG_LOC_B; endsequence
    sequence s_key_rd; flash_rd && flash_addr == `KEY_LOC; endsequence
    property p_mode_hold;
        external_reset_input && $past(external_reset_input, 6)
            |-> $stable(boot_mode);
    endproperty
    property p_user_map;
        boot_done && boot_mode == `MODE_USER
            |-> user_flash_enable && !fetch_from_test_flash;
    endproperty
    property p_std_map;
        standard_boot_loader && boot_mode == `MODE_STANDARD
            |-> fetch_from_test_flash && user_flash_enable;
    endproperty
    property p_sel_map;
        flash_rd |-> boot_mode == `MODE_SELECTIVE && fetch_from_test_flash
            && user_flash_enable;
    endproperty
    property p_sig_pair; s_read_a |=> s_read_b; endproperty
    property p_after_sig;
        s_read_b |-> ##[1:8] (soft_reset_req ||
                              (flash_rd && flash_addr == `KEY_LOC));
    endproperty
    property p_soft_rst;
        $rose(run_user_code) && boot_mode == `MODE_SELECTIVE
            |-> soft_reset_req ##1 !soft_reset_req;
    endproperty
    property p_key_fail; s_key_rd |-> !run_user_code; endproperty
    property p_one_way;
        $onehot0({serial_boot_start, can_boot_start, halt_loop});
    endproperty
    property p_serial;
        standard_boot_loader && !can_boot_start
            && $fell(serial0_receive_line) |-> ##[1:6] serial_boot_start;
    endproperty
    property p_can; $rose(can_boot_start) |-> can_low_reg >= 4'h8; endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("boot mode moved while reset pin stayed high");
    a_user_map: assert property (p_user_map)
        else $error("user mode flash mapping wrong");
    a_std_map: assert property (p_std_map)
        else $error("standard loader mapping wrong");
    a_sel_map: assert property (p_sel_map)
        else $error("flash read outside selective redirect");
    a_sig_pair: assert property (p_sig_pair)
        else $error("second signature word not read next");
    a_after_sig: assert property (p_after_sig)
        else $error("no outcome after signature read");
    a_soft_rst: assert property (p_soft_rst)
        else $error("soft reset pulse missing or long");
    a_key_fail: assert property (p_key_fail)
        else $error("key read while user code runs");
    a_one_way: assert property (p_one_way)
        else $error("more than one boot outcome");
    a_serial: assert property (p_serial)
        else $error("serial start not taken");
    a_can: assert property (p_can)
        else $error("can start without eight dominant samples");
endmodule // boot_select_asserts

// file: bench/flash_model.sv
// flash array stand-in answering boot reads one cycle later
`timescale 1ns/10ps
`include "boot_select_defs.vh"
module flash_model (
    input  wire                clk,         // system clock
    input  wire                flash_rd,    // read strobe
    input  wire [`ADDR_W-1:0]  flash_addr,  // read address
    input  wire [`WORD_W-1:0]  word_a,      // first signature word
    input  wire [`WORD_W-1:0]  word_b,      // second signature word
    input  wire [`WORD_W-1:0]  key_word,    // user key word
    output reg  [`WORD_W-1:0]  flash_rdata  // read data
);
    initial flash_rdata = 16'h0000;
    // data stands only in the cycle after the strobe; otherwise the bus
    // toggles so a late sample never hits a stale match
    always @(posedge clk) begin
        if (flash_rd) begin
            case (flash_addr)
                `SIG_LOC_A: flash_rdata <= word_a;
                `SIG_LOC_B: flash_rdata <= word_b;
                `KEY_LOC:   flash_rdata <= key_word;
                default:    flash_rdata <= ~flash_rdata;
            endcase
        end else begin
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule // flash_model

// file: bench/tb_top.sv
// self-checking testbench for the boot selection block
`timescale 1ns/10ps
`include "boot_select_defs.vh"
module tb_top;
    reg clk = 1'b0, srst = 1'b1, external_reset_input = 1'b0;
    reg boot_select_upper = 1'b1, boot_select_lower = 1'b1;
    reg serial0_receive_line = 1'b1, can_channel1_receive_line = 1'b1;
    reg [`WORD_W-1:0] ref_signature = 16'h5d5a, word_a = 16'h1234;
    reg [`WORD_W-1:0] word_b = 16'h4f6e, key_word = 16'h0000;
    wire [`WORD_W-1:0] flash_rdata;
    wire [`ADDR_W-1:0] flash_addr;
    wire [`MODE_W-1:0] boot_mode;
    wire flash_rd, fetch_from_test_flash, user_flash_enable, soft_reset_req;
    wire run_user_code, standard_boot_loader, serial_boot_start;
    wire can_boot_start, halt_loop, boot_done;
    int n_mismatch = 0;
    int samples_checked = 0;
    boot_select dut_u (
        .clk                       (clk),
        .srst                      (srst),
        .external_reset_input      (external_reset_input),
        .boot_select_upper         (boot_select_upper),
        .boot_select_lower         (boot_select_lower),
        .serial0_receive_line      (serial0_receive_line),
        .can_channel1_receive_line (can_channel1_receive_line),
        .ref_signature             (ref_signature),
        .flash_addr                (flash_addr),
        .flash_rd                  (flash_rd),
        .flash_rdata               (flash_rdata),
        .boot_mode                 (boot_mode),
        .fetch_from_test_flash     (fetch_from_test_flash),
        .user_flash_enable         (user_flash_enable),
        .soft_reset_req            (soft_reset_req),
        .run_user_code             (run_user_code),
        .standard_boot_loader      (standard_boot_loader),
        .serial_boot_start         (serial_boot_start),
        .can_boot_start            (can_boot_start),
        .halt_loop                 (halt_loop),
        .boot_done                 (boot_done)
    );
    flash_model flash_u (.clk(clk), .flash_rd(flash_rd),
        .flash_addr(flash_addr), .word_a(word_a), .word_b(word_b),
        .key_word(key_word), .flash_rdata(flash_rdata));
    initial forever #4 clk = ~clk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: pick = boot_done;
            1: pick = standard_boot_loader;
            2: pick = serial_boot_start;
            3: pick = can_boot_start;
            default: pick = run_user_code;
        endcase
    endfunction
    // bounded wait; a hang ends the run through the closing report
    task automatic wait_on(input int k);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (pick(k) === 1'b1) return;
        end
        n_mismatch++;
        $display("CHECK FAILED %0t: wait timed out", $time);
        conclude;
    endtask
    // straps are set while the pin holds reset; host never straps 00
    task automatic boot(input logic [1:0] sel);
        @(posedge clk);
        external_reset_input <= 1'b0;
        serial0_receive_line <= 1'b1;
        can_channel1_receive_line <= 1'b1;
        {boot_select_upper, boot_select_lower} <= sel;
        repeat (6) @(posedge clk);
        external_reset_input <= 1'b1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_user;
        boot(`SEL_USER);
        wait_on(0);
        chk(boot_mode, `MODE_USER);
        chk(fetch_from_test_flash, 1'b0);
        chk(user_flash_enable, 1'b1);
        @(posedge clk);
        boot_select_upper <= 1'b0;
        repeat (10) @(posedge clk);
        #1 chk(boot_mode, `MODE_USER);
    endtask
    task automatic t_standard;
        boot(`SEL_STANDARD);
        wait_on(1);
        chk(boot_mode, `MODE_STANDARD);
        chk(fetch_from_test_flash, 1'b1);
        chk(user_flash_enable, 1'b1);
        @(posedge clk) serial0_receive_line <= 1'b0;
        wait_on(2);
        chk(can_boot_start, 1'b0);
    endtask
    // a short dominant glitch must not start can bootstrapping
    task automatic t_std_can;
        boot(`SEL_STANDARD);
        wait_on(1);
        @(posedge clk) can_channel1_receive_line <= 1'b0;
        repeat (4) @(posedge clk);
        can_channel1_receive_line <= 1'b1;
        repeat (12) @(posedge clk);
        #1 chk(can_boot_start, 1'b0);
        @(posedge clk) can_channel1_receive_line <= 1'b0;
        wait_on(3);
        chk(serial_boot_start, 1'b0);
    endtask
    task automatic t_sel_pass;
        boot(`SEL_SELECTIVE);
        wait_on(4);
        chk(soft_reset_req, 1'b1);
        chk(boot_mode, `MODE_SELECTIVE);
        chk(fetch_from_test_flash, 1'b0);
    endtask
    // bad signature: each key value, then both lines go low together
    task automatic t_sel_keys;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            word_b <= 16'h4f6f;
            key_word <= {14'h0000, k[1:0]};
            boot(`SEL_SELECTIVE);
            // only the halt key raises boot_done, so wait past the key
            // decode by a fixed count instead of on a flag
            repeat (12) @(posedge clk);
            #1 chk(run_user_code, 1'b0);
            chk(standard_boot_loader, k == 0);
            chk(halt_loop, k == 3);
            @(posedge clk);
            serial0_receive_line <= 1'b0;
            can_channel1_receive_line <= 1'b0;
            repeat (20) @(posedge clk);
            #1 chk(serial_boot_start, k < 2);
            chk(can_boot_start, k == 2);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_user;
        t_standard;
        t_std_can;
        t_sel_pass;
        t_sel_keys;
        conclude;
    end
endmodule // tb_top
bind boot_select boot_select_asserts chk_u (
    .clk                       (clk),
    .srst                      (srst),
    .external_reset_input      (external_reset_input),
    .boot_select_upper         (boot_select_upper),
    .boot_select_lower         (boot_select_lower),
    .serial0_receive_line      (serial0_receive_line),
    .can_channel1_receive_line (can_channel1_receive_line),
    .ref_signature             (ref_signature),
    .flash_rdata               (flash_rdata),
    .flash_addr                (flash_addr),
    .boot_mode                 (boot_mode),
    .flash_rd                  (flash_rd),
    .fetch_from_test_flash     (fetch_from_test_flash),
    .user_flash_enable         (user_flash_enable),
    .soft_reset_req            (soft_reset_req),
    .run_user_code             (run_user_code),
    .standard_boot_loader      (standard_boot_loader),
    .serial_boot_start         (serial_boot_start),
    .can_boot_start            (can_boot_start),
    .halt_loop                 (halt_loop),
    .boot_done                 (boot_done)
);
